/* File: rtl/bdmc_pkg.sv */
// Package: constants and types of the bus driver mode control block
package bdmc_pkg;
   // Timing
   localparam int CLK_MHZ = 40;
   localparam int LOGIC_FILTER_NS = 500;
   localparam int FILT_CYC_RAW = (LOGIC_FILTER_NS * CLK_MHZ + 999) / 1000;
   localparam int FILT_CYC = (FILT_CYC_RAW < 1) ? 1 : FILT_CYC_RAW;
   localparam int MODE_CHANGE_NS = 1000;
   localparam int MODE_CHG_RAW = (MODE_CHANGE_NS * CLK_MHZ) / 1000;
   localparam int MODE_CHG_CYC = (MODE_CHG_RAW < 1) ? 1 : MODE_CHG_RAW;
   localparam int FILT_W = $clog2(FILT_CYC + 1);
   localparam logic [FILT_W-1:0] FILT_LAST = FILT_W'(FILT_CYC - 1);
   localparam logic [FILT_W-1:0] FILT_RST = '0;

   // Synchroniser bit positions
   localparam int SI_MODE = 0;
   localparam int SI_TX_ENABLE_N_N = 1;
   localparam int SI_GE = 2;
   localparam int SI_TXD = 3;
   localparam int SI_VCC_UV = 4;
   localparam int SI_VIO_UV = 5;
   localparam int SI_POR = 6;
   localparam int SI_WAKE = 7;
   localparam int SI_TOUT = 8;
   localparam int SI_OTEMP = 9;
   localparam int SI_BERR = 10;
   localparam int SI_RXD = 11;
   localparam int SI_RXACT = 12;
   localparam int SYNC_W = 13;
   localparam logic [SYNC_W-1:0] SYNC_RST = 13'h0002;

   // Input defaults when the logic supply is gone
   localparam logic TXD_DFLT = 1'b0;
   localparam logic TX_ENABLE_N_N_DFLT = 1'b1;
   localparam logic MODE_DFLT = 1'b0;
   localparam logic GE_DFLT = 1'b0;

   // Register bus
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h00;
   localparam logic [31:0] RDATA_RST = 32'h0000_0000;

   // Status word fields
   localparam int FLAG_W = 8;
   localparam int F_VCC_UV = 0;
   localparam int F_VIO_UV = 1;
   localparam int F_FORCED = 2;
   localparam int F_GUARD = 3;
   localparam int F_TOUT = 4;
   localparam int F_OTEMP = 5;
   localparam int F_BERR = 6;
   localparam int F_WAKE = 7;
   localparam int ST_BUSACT = 8;
   localparam int ST_MODE_LO = 9;
   localparam int ST_MODE_REQ = 11;
   localparam int ST_TXON = 12;
   localparam logic [FLAG_W-1:0] FLAGS_RST = 8'h00;
   localparam logic [FLAG_W-1:0] ERR_MASK = 8'h7f;

   typedef enum logic [1:0] {
      OFF_CONDITION = 2'b00,
      STANDBY_MODE = 2'b01,
      NORMAL_MODE = 2'b10
   } bdmc_mode_e;

   typedef struct packed {
      logic [SYNC_W-1:0] s1;
      logic [SYNC_W-1:0] s2;
   } bdmc_sync_s;

   typedef struct packed {
      bdmc_mode_e mode;
      logic mode_req;
      logic [FILT_W-1:0] filt_cnt;
      logic tx_enable_n_n_d;
      logic tx_armed;
      logic tx_on;
      logic [FLAG_W-1:0] flags;
      logic bus_act;
      logic bus_plus;
      logic bus_minus;
      logic drive_en;
      logic bias_mid;
      logic rx_data;
      logic err_n;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } bdmc_state_s;
endpackage

/* File: rtl/bdmc_sync.sv */
// Two-stage synchroniser for all pin and monitor inputs
`timescale 1ns/1ps
module bdmc_sync (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Data
   input wire logic [bdmc_pkg::SYNC_W-1:0] async_in,
   output logic [bdmc_pkg::SYNC_W-1:0] sync_out
);
   import bdmc_pkg::*;

   bdmc_sync_s r;
   bdmc_sync_s n;

   // First stage is read by the second stage only
   always_comb begin
      n = r;
      n.s1 = async_in;
      n.s2 = r.s1;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         r <= '{s1: SYNC_RST, s2: SYNC_RST};
      end else begin
         r <= n;
      end
   end

   assign sync_out = r.s2;
endmodule

/* File: rtl/bdmc_top.sv */
// Mode control, transmitter gating and status of the bus driver
`timescale 1ns/1ps
module bdmc_top (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Controller interface
   input wire logic tx_data,
   input wire logic tx_enable_n,
   output logic rx_data,
   // Guardian and host interface
   input wire logic guardian_enable,
   input wire logic mode_select_n_standby,
   output logic error_out_n,
   // Supply monitors and detectors
   input wire logic vcc_undervoltage,
   input wire logic vio_undervoltage,
   input wire logic below_power_on_reset_threshold,
   input wire logic wake_detected,
   input wire logic tx_timeout,
   input wire logic overtemperature,
   input wire logic bus_error,
   // Bus receiver and driver
   input wire logic bus_rx_data,
   input wire logic bus_rx_active,
   output logic bus_line_plus,
   output logic bus_line_minus,
   output logic bus_drive_en,
   output logic bus_bias_mid,
   output logic bus_activity_flag,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [bdmc_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   import bdmc_pkg::*;

   bdmc_state_s r;
   bdmc_state_s n;
   logic [SYNC_W-1:0] pins_raw;
   logic [SYNC_W-1:0] s;
   logic vio_uv;
   logic vcc_uv;
   logic uv;
   logic por_low;
   logic txd;
   logic tx_enable_n_n;
   logic ge;
   logic mode_sel;
   logic tx_enable_n_fall;
   logic is_normal;
   logic is_standby;
   logic st_hit;
   logic wr_status;
   logic [FLAG_W-1:0] set_f;
   logic [FLAG_W-1:0] clr_f;
   logic [31:0] status_w;

   assign pins_raw[SI_MODE] = mode_select_n_standby;
   assign pins_raw[SI_TX_ENABLE_N_N] = tx_enable_n;
   assign pins_raw[SI_GE] = guardian_enable;
   assign pins_raw[SI_TXD] = tx_data;
   assign pins_raw[SI_VCC_UV] = vcc_undervoltage;
   assign pins_raw[SI_VIO_UV] = vio_undervoltage;
   assign pins_raw[SI_POR] = below_power_on_reset_threshold;
   assign pins_raw[SI_WAKE] = wake_detected;
   assign pins_raw[SI_TOUT] = tx_timeout;
   assign pins_raw[SI_OTEMP] = overtemperature;
   assign pins_raw[SI_BERR] = bus_error;
   assign pins_raw[SI_RXD] = bus_rx_data;
   assign pins_raw[SI_RXACT] = bus_rx_active;

   bdmc_sync u_sync (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .async_in(pins_raw),
      .sync_out(s)
   );

   // Without the logic supply the pins float and the pull defaults apply
   assign vio_uv = s[SI_VIO_UV];
   assign vcc_uv = s[SI_VCC_UV];
   assign uv = vio_uv | vcc_uv;
   assign por_low = s[SI_POR];
   assign txd = vio_uv ? TXD_DFLT : s[SI_TXD];
   assign tx_enable_n_n = vio_uv ? TX_ENABLE_N_N_DFLT : s[SI_TX_ENABLE_N_N];
   assign ge = vio_uv ? GE_DFLT : s[SI_GE];
   assign mode_sel = vio_uv ? MODE_DFLT : s[SI_MODE];
   assign tx_enable_n_fall = r.tx_enable_n_n_d & ~tx_enable_n_n;
   assign is_normal = (r.mode == NORMAL_MODE);
   assign is_standby = (r.mode == STANDBY_MODE);

   // Sticky flag events
   always_comb begin
      set_f = '0;
      set_f[F_VCC_UV] = is_normal & vcc_uv;
      set_f[F_VIO_UV] = is_normal & vio_uv;
      set_f[F_FORCED] = is_normal & uv & r.mode_req;
      set_f[F_GUARD] = is_normal & ~ge;
      set_f[F_TOUT] = is_normal & r.tx_on & s[SI_TOUT];
      set_f[F_OTEMP] = is_normal & r.tx_on & s[SI_OTEMP];
      set_f[F_BERR] = is_normal & r.tx_on & s[SI_BERR];
      // Detector runs in Normal too, but only a Standby request reports
      set_f[F_WAKE] = is_standby & ~r.mode_req & s[SI_WAKE];
   end

   // Register access
   assign st_hit = (paddr == STATUS_OFS);
   assign wr_status = psel & penable & r.pready & pwrite & st_hit;
   assign clr_f = wr_status ? pwdata[FLAG_W-1:0] : '0;

   always_comb begin
      status_w = '0;
      status_w[FLAG_W-1:0] = r.flags;
      status_w[ST_BUSACT] = r.bus_act;
      status_w[ST_MODE_LO +: 2] = r.mode;
      status_w[ST_MODE_REQ] = r.mode_req;
      status_w[ST_TXON] = r.tx_on;
   end

   always_comb begin
      n = r;

      // Mode request filter: a change must hold for the filter time
      if (mode_sel != r.mode_req) begin
         if (r.filt_cnt == FILT_LAST) begin
            n.mode_req = mode_sel;
            n.filt_cnt = FILT_RST;
         end else begin
            n.filt_cnt = r.filt_cnt + 1'b1;
         end
      end else begin
         n.filt_cnt = FILT_RST;
      end

      // Mode state machine
      case (r.mode)
         OFF_CONDITION: begin
            n.mode = STANDBY_MODE;
         end
         STANDBY_MODE: begin
            if (r.mode_req && !uv) begin
               n.mode = NORMAL_MODE;
            end
         end
         NORMAL_MODE: begin
            if (!r.mode_req || uv) begin
               n.mode = STANDBY_MODE;
            end
         end
         default: begin
            n.mode = OFF_CONDITION;
         end
      endcase
      if (por_low) begin
         n.mode = OFF_CONDITION;
      end

      // Set wins over a software clear in the same cycle
      n.flags = (r.flags & ~clr_f) | set_f;

      // Transmitter gating
      n.tx_enable_n_n_d = tx_enable_n_n;
      if (!is_normal || tx_enable_n_n || !ge || s[SI_TOUT] || s[SI_OTEMP]) begin
         n.tx_armed = 1'b0;
         n.tx_on = 1'b0;
      end else begin
         if (tx_enable_n_fall) begin
            n.tx_armed = 1'b1;
         end
         if (r.tx_armed && !txd) begin
            n.tx_on = 1'b1;
         end
      end
      if (n.mode != NORMAL_MODE) begin
         n.tx_armed = 1'b0;
         n.tx_on = 1'b0;
      end

      // Differential drive
      n.drive_en = n.tx_on;
      n.bus_plus = n.tx_on & txd;
      n.bus_minus = n.tx_on & ~txd;
      n.bias_mid = (n.mode == NORMAL_MODE);

      // Bus activity only seen in Normal
      n.bus_act = (n.mode == NORMAL_MODE) & s[SI_RXACT];

      // Receive and error outputs
      case (n.mode)
         NORMAL_MODE: begin
            n.rx_data = s[SI_RXACT] ? s[SI_RXD] : 1'b1;
            n.err_n = ~|(n.flags & ERR_MASK);
         end
         STANDBY_MODE: begin
            if (vio_uv) begin
               n.rx_data = 1'b0;
               n.err_n = 1'b0;
            end else if (n.mode_req) begin
               // A Normal request about to be served is no error
               n.rx_data = 1'b1;
               n.err_n = ~uv;
            end else begin
               n.rx_data = ~n.flags[F_WAKE];
               n.err_n = ~n.flags[F_WAKE];
            end
         end
         default: begin
            n.rx_data = 1'b0;
            n.err_n = 1'b0;
         end
      endcase

      // APB: zero-wait access, ready set from the setup cycle
      n.pready = psel & ~penable;
      n.pslverr = 1'b0;
      n.prdata = RDATA_RST;
      if (psel && !penable && st_hit) begin
         n.prdata = status_w;
      end else if (psel && !penable) begin
         n.pslverr = 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         r <= '{mode: OFF_CONDITION, mode_req: MODE_DFLT,
                filt_cnt: FILT_RST, tx_enable_n_n_d: TX_ENABLE_N_N_DFLT,
                tx_armed: 1'b0, tx_on: 1'b0, flags: FLAGS_RST,
                bus_act: 1'b0, bus_plus: 1'b0, bus_minus: 1'b0,
                drive_en: 1'b0, bias_mid: 1'b0, rx_data: 1'b0,
                err_n: 1'b0, pready: 1'b0, pslverr: 1'b0,
                prdata: RDATA_RST};
      end else begin
         r <= n;
      end
   end

   assign rx_data = r.rx_data;
   assign error_out_n = r.err_n;
   assign bus_line_plus = r.bus_plus;
   assign bus_line_minus = r.bus_minus;
   assign bus_drive_en = r.drive_en;
   assign bus_bias_mid = r.bias_mid;
   assign bus_activity_flag = r.bus_act;
   assign prdata = r.prdata;
   assign pready = r.pready;
   assign pslverr = r.pslverr;

   // Checks
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   off_hold_a: assert property (por_low |=> r.mode == OFF_CONDITION)
      else $error("mode not Off while supply below threshold");

   off_outputs_a: assert property (
      r.mode == OFF_CONDITION |-> !r.err_n && !r.rx_data && !r.drive_en)
      else $error("outputs not low in Off");

   first_standby_a: assert property (
      r.mode == OFF_CONDITION && !por_low |=> r.mode == STANDBY_MODE)
      else $error("Off not left for Standby");

   drive_gate_a: assert property (
      r.drive_en |-> $past(ge) && !$past(tx_enable_n_n) && is_normal)
      else $error("driving without enable or guardian");

   tx_start_a: assert property (
      $rose(r.tx_on) |-> $past(r.tx_armed) && !$past(txd))
      else $error("transmitter on without armed start");

   normal_entry_a: assert property (
      $rose(is_normal) |-> $past(r.mode_req) && !$past(uv))
      else $error("Normal entered without request or supply");

   uv_force_a: assert property (is_normal && uv |=> is_standby)
      else $error("undervoltage did not force Standby");

   uv_return_a: assert property (
      is_standby && r.mode_req && !uv && !por_low |=> is_normal)
      else $error("no return to Normal after recovery");

   wake_report_a: assert property (
      is_standby && !r.mode_req && !vio_uv && !por_low && s[SI_WAKE]
      |=> ##1 !r.err_n && !r.rx_data)
      else $error("wake-up not reported");

   wake_quiet_a: assert property (
      $rose(r.flags[F_WAKE]) |-> $past(is_standby) && !$past(r.mode_req))
      else $error("wake-up flagged outside Standby request");

   filter_hold_a: assert property (
      $changed(r.mode_req) |-> $past(r.filt_cnt) == FILT_LAST)
      else $error("mode request changed before filter time");

   standby_quiet_a: assert property (
      !is_normal |-> !r.bus_act && !r.drive_en)
      else $error("bus activity or drive outside Normal");

   forced_report_a: assert property (
      is_standby && n.mode_req && uv && !vio_uv && !por_low
      |=> !r.err_n && r.rx_data)
      else $error("forced Standby not shown on error output");

   normal_error_a: assert property (
      is_normal && r.flags[F_BERR:F_VCC_UV] != '0 |-> !r.err_n)
      else $error("error flag set but error output high");

   normal_quiet_a: assert property (
      is_normal && r.flags[F_BERR:F_VCC_UV] == '0 |-> r.err_n)
      else $error("error output low in Normal without error flag");

   guard_flag_a: assert property (
      is_normal && !ge |=> r.flags[F_GUARD] && !r.drive_en)
      else $error("guardian low not flagged or not obeyed");

   tx_inputs_a: assert property (
      is_standby |=> !r.tx_armed && !r.tx_on)
      else $error("transmitter armed in Standby");

   bias_mode_a: assert property (r.bias_mid == is_normal)
      else $error("bus bias does not follow the mode");

   apb_ready_a: assert property (
      psel && !penable |=> r.pready ##1 !r.pready)
      else $error("status access not answered in one cycle");

   uv_flag_a: assert property (
      is_normal && vcc_uv |=> r.flags[F_VCC_UV])
      else $error("undervoltage in Normal not flagged");

   arm_edge_a: assert property (
      $rose(r.tx_armed) |-> $past(tx_enable_n_fall))
      else $error("transmitter armed without enable edge");

   enter_normal_c: cover property ($rose(is_normal));
   tx_active_c: cover property ($rose(r.tx_on));
   wake_seen_c: cover property ($fell(r.err_n) && is_standby);
   forced_stby_c: cover property ($rose(r.flags[F_FORCED]));
   guard_drop_c: cover property (is_normal && !ge && r.tx_on);
endmodule

/* File: tb/bdmc_partner.sv */
// Bus receiver model that reflects the driven bus back to the block
`timescale 1ns/1ps
module bdmc_partner (
   // Clock
   input wire logic clk_sys,
   // Driven bus
   input wire logic bus_line_plus,
   input wire logic bus_line_minus,
   input wire logic bus_drive_en,
   // Received bus
   output logic bus_rx_data,
   output logic bus_rx_active
);
   // An idle bus reads as Data_1, as a real receiver would report it
   always @(posedge clk_sys) begin
      bus_rx_active <= bus_drive_en & (bus_line_plus ^ bus_line_minus);
      bus_rx_data <= bus_drive_en ? bus_line_plus : 1'b1;
   end
endmodule

/* File: tb/tb.sv */
// Self-checking testbench of the bus driver mode control block
`timescale 1ns/1ps
module tb;
   import bdmc_pkg::*;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic tx_data = 1'b0, tx_enable_n = 1'b1, guardian_enable = 1'b0;
   logic mode_select_n_standby = 1'b0, vcc_undervoltage = 1'b0;
   logic vio_undervoltage = 1'b0, below_power_on_reset_threshold = 1'b0;
   logic wake_detected = 1'b0, tx_timeout = 1'b0, overtemperature = 1'b0;
   logic bus_error = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic rx_data, error_out_n, bus_line_plus, bus_line_minus, bus_drive_en;
   logic bus_bias_mid, bus_activity_flag, bus_rx_data, bus_rx_active;
   logic [31:0] prdata, rd;
   logic pready, pslverr, er;
   logic [15:0] seed = 16'ha64b;
   int fail_count = 0;
   int n_tests = 0;

   always #12.5 clk_sys = ~clk_sys;

   bdmc_top bdmc_top_i (.clk_sys(clk_sys), .rst_n(rst_n), .tx_data(tx_data),
      .tx_enable_n(tx_enable_n), .rx_data(rx_data),
      .guardian_enable(guardian_enable),
      .mode_select_n_standby(mode_select_n_standby),
      .error_out_n(error_out_n), .vcc_undervoltage(vcc_undervoltage),
      .vio_undervoltage(vio_undervoltage),
      .below_power_on_reset_threshold(below_power_on_reset_threshold),
      .wake_detected(wake_detected), .tx_timeout(tx_timeout),
      .overtemperature(overtemperature), .bus_error(bus_error),
      .bus_rx_data(bus_rx_data), .bus_rx_active(bus_rx_active),
      .bus_line_plus(bus_line_plus), .bus_line_minus(bus_line_minus),
      .bus_drive_en(bus_drive_en), .bus_bias_mid(bus_bias_mid),
      .bus_activity_flag(bus_activity_flag), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));

   bdmc_partner bdmc_partner_i (.clk_sys(clk_sys),
      .bus_line_plus(bus_line_plus), .bus_line_minus(bus_line_minus),
      .bus_drive_en(bus_drive_en), .bus_rx_data(bus_rx_data),
      .bus_rx_active(bus_rx_active));

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   function automatic logic [1:0] mode_code(input logic normal);
      return normal ? 2'b10 : 2'b01;
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: saw %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   // Holds the request until ready; only the watchdog bounds a hang
   task automatic apb(input logic [7:0] a, input logic w,
                      input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic close_out;
      $display("Checks %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge clk_sys);
      fail_count++;
      close_out();
   end

   initial begin
      wt(3);
      @(negedge clk_sys);
      chk(error_out_n, 0);
      chk(rx_data, 0);
      wt(9);
      rst_n <= 1'b1;
      wt(4);
      @(negedge clk_sys);
      chk(error_out_n, 1);
      chk(rx_data, 1);
      chk(bus_bias_mid, 0);
      apb(STATUS_OFS, 1'b0, '0);
      chk(rd[10:9], mode_code(1'b0));
      apb({seed[7:2], 2'b00} | 8'h04, 1'b0, '0);
      chk(er, 1);
      chk(rd, 0);
      // Transmit inputs must have no effect while in Standby
      guardian_enable <= 1'b1;
      tx_enable_n <= 1'b0;
      wt(10);
      @(negedge clk_sys);
      chk(bus_drive_en, 0);
      chk(bus_activity_flag, 0);
      @(posedge clk_sys);
      tx_enable_n <= 1'b1;
      wake_detected <= 1'b1;
      wt(1);
      wake_detected <= 1'b0;
      wt(5);
      @(negedge clk_sys);
      chk(error_out_n, 0);
      chk(rx_data, 0);
      apb(STATUS_OFS, 1'b1, 32'h0000_0080);
      wt(3);
      @(negedge clk_sys);
      chk(error_out_n, 1);
      // A pulse well below the filter time must not change the mode
      @(posedge clk_sys);
      mode_select_n_standby <= 1'b1;
      wt(5);
      mode_select_n_standby <= 1'b0;
      wt(30);
      apb(STATUS_OFS, 1'b0, '0);
      chk(rd[10:9], mode_code(1'b0));
      mode_select_n_standby <= 1'b1;
      wt(MODE_CHG_CYC);
      @(negedge clk_sys);
      chk(bus_bias_mid, 1);
      chk(error_out_n, 1);
      apb(STATUS_OFS, 1'b0, '0);
      chk(rd[10:9], mode_code(1'b1));
      wake_detected <= 1'b1;
      wt(1);
      wake_detected <= 0;
      wt(5);
      @(negedge clk_sys);
      chk(error_out_n, 1);
      apb(STATUS_OFS, 1'b0, '0);
      chk(rd[7], 0);
      chk(rd[8], 0);
      tx_enable_n <= 1'b0;
      wt(4);
      for (int i = 0; i < 6; i++) begin
         tx_data <= (i == 0) ? 1'b0 : seed[0];
         seed = lfsr(seed);
         wt(10);
         @(negedge clk_sys);
         chk(bus_drive_en, 1);
         chk(bus_line_plus, tx_data);
         chk(bus_line_minus, !tx_data);
         chk(rx_data, tx_data);
         chk(bus_activity_flag, 1);
         @(posedge clk_sys);
      end
      tx_enable_n <= 1'b1;
      wt(6);
      @(negedge clk_sys);
      chk(bus_drive_en, 0);
      chk({bus_line_plus, bus_line_minus}, 0);
      @(posedge clk_sys);
      tx_enable_n <= 1'b0;
      tx_data <= 1'b0;
      wt(8);
      @(negedge clk_sys);
      chk(bus_drive_en, 1);
      @(posedge clk_sys);
      guardian_enable <= 1'b0;
      wt(6);
      @(negedge clk_sys);
      chk(bus_drive_en, 0);
      chk(error_out_n, 0);
      apb(STATUS_OFS, 1'b0, '0);
      chk(rd[3], 1);
      guardian_enable <= 1'b1;
      tx_enable_n <= 1'b1;
      wt(4);
      tx_enable_n <= 1'b0;
      wt(8);
      @(negedge clk_sys);
      chk(bus_drive_en, 1);
      @(posedge clk_sys);
      overtemperature <= 1'b1;
      wt(6);
      @(negedge clk_sys);
      chk(bus_drive_en, 0);
      apb(STATUS_OFS, 1'b0, '0);
      chk(rd[5], 1);
      overtemperature <= 1'b0;
      tx_enable_n <= 1'b1;
      apb(STATUS_OFS, 1'b1, 32'h0000_00ff);
      wt(3);
      @(negedge clk_sys);
      chk(error_out_n, 1);
      @(posedge clk_sys);
      vcc_undervoltage <= 1'b1;
      wt(6);
      @(negedge clk_sys);
      chk(error_out_n, 0);
      chk(rx_data, 1);
      apb(STATUS_OFS, 1'b0, '0);
      chk(rd[10:9], mode_code(1'b0));
      chk(rd[2], 1);
      vcc_undervoltage <= 1'b0;
      wt(6);
      apb(STATUS_OFS, 1'b0, '0);
      chk(rd[10:9], mode_code(1'b1));
      below_power_on_reset_threshold <= 1'b1;
      wt(6);
      @(negedge clk_sys);
      chk(error_out_n, 0);
      chk(rx_data, 0);
      apb(STATUS_OFS, 1'b0, '0);
      chk(rd[10:9], 0);
      close_out();
   end
endmodule
